// File: src/irq_route_pkg.sv
// Purpose: Shared constants and carriers for the audio interrupt router
// Assumes: APB register map with 32-bit words, one word per register
// Notes:   Printed offsets are not all multiples of four, so they are indices
package irq_route_pkg;

    // Register indices, byte address is four times the index
    localparam logic [7:0] IDX_SRC_STATUS   = 8'h06;
    localparam logic [7:0] IDX_SRC_MASK     = 8'h07;
    localparam logic [7:0] IDX_PIN_CHAN0    = 8'h20;
    localparam logic [7:0] IDX_PIN_CHAN1    = 8'h21;
    localparam logic [7:0] IDX_PIN_CHAN2    = 8'h22;
    localparam logic [7:0] IDX_DRQ_LATCH    = 8'h25;
    localparam logic [7:0] IDX_HWVOL_ROUTE  = 8'h27;
    localparam logic [7:0] IDX_MIDI_ROUTE   = 8'h28;
    localparam logic [7:0] IDX_VOL_CTRL     = 8'h64;
    localparam logic [7:0] IDX_VOL_CLEAR    = 8'h66;
    localparam logic [7:0] IDX_CH2_CTRL     = 8'h7a;
    localparam logic [7:0] IDX_A1_EXT_CTRL  = 8'hb1;
    // Chosen indices for logical-device registers and audio ports
    localparam logic [7:0] IDX_A1_ROUTE     = 8'hc0;
    localparam logic [7:0] IDX_A2_ROUTE     = 8'hc1;
    localparam logic [7:0] IDX_LDN_ACT      = 8'hc2;
    localparam logic [7:0] IDX_A1_POLL      = 8'hc3;
    localparam logic [7:0] IDX_A1_ACK       = 8'hc4;
    localparam logic [7:0] IDX_CH2_COUNT    = 8'hc5;
    localparam logic [7:0] IDX_SW_RESET     = 8'hc6;

    // Field positions
    localparam int BIT_CH2_GATE    = 6;
    localparam int BIT_CH2_REQ     = 7;
    localparam int BIT_VOL_GATE    = 1;
    localparam int BIT_VOL_REQ     = 3;
    localparam int BIT_MIDI_GATE   = 6;
    localparam int BIT_LATCH_EN    = 7;

    // Reset values
    localparam logic [6:0] MASK_RESET      = 7'h7f;
    localparam logic [7:0] PIN_CHAN_RESET  = 8'h00;
    localparam logic [7:0] CH2_COUNT_RESET = 8'h40;

    // Source order in status, mask and routing
    localparam int SRC_A1    = 0;
    localparam int SRC_A2    = 1;
    localparam int SRC_VOL   = 2;
    localparam int SRC_MIDI  = 3;
    localparam int SRC_CD    = 4;
    localparam int SRC_MODEM = 5;
    localparam int SRC_GP    = 6;
    localparam int NUM_SRC   = 7;
    localparam int NUM_PINS  = 5;

    // Logical-device activation bits
    localparam int LDN_AUDIO = 0;
    localparam int LDN_CD    = 1;
    localparam int LDN_MODEM = 2;
    localparam int LDN_MIDI  = 3;
    localparam int LDN_GP    = 4;

    // Latch release window, least time taken: 8 ms at 40 MHz
    localparam int  CLK_MHZ          = 40;
    localparam int  DRQ_HOLD_MS      = 8;
    localparam int  DRQ_HOLD_CYCLES  = DRQ_HOLD_MS * 1000 * CLK_MHZ;

    typedef struct packed {
        logic       valid;
        logic [2:0] pin;
    } route_s;

    typedef struct packed {
        logic [2:0] req;
        logic [2:0] ack_n;
    } drq_s;

endpackage

// File: src/drq_latch.sv
// Purpose: Holds one audio DMA request high until a release event
// Assumes: Request and acknowledge are synchronous to clock_i
// Notes:   Release timer length is a parameter so simulation can shorten it
`timescale 1ns/1ps
module drq_latch
    import irq_route_pkg::*;
#(
    parameter int HOLD_CYCLES = DRQ_HOLD_CYCLES
)(
    input  wire logic clock_i,    // System clock
    input  wire logic rstn_i,     // Sync reset, active low
    input  wire logic enable_i,   // Latch feature on
    input  wire logic req_i,      // Raw DMA request
    input  wire logic ack_n_i,    // DMA acknowledge, active low
    output logic      req_o       // Request toward the pin
);

    logic        held;
    logic [31:0] low_count;

    ////////////////////////////////////////////////////////////////////
    // Hold state; acknowledge with request low, or timeout, releases
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i || !enable_i)
            held <= 1'b0;
        else if (req_i)
            held <= 1'b1;
        else if (!ack_n_i || low_count >= 32'(HOLD_CYCLES - 1))
            held <= 1'b0;
    end

    // Counts cycles with raw request low while held
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i || req_i || !held)
            low_count <= 32'h0;
        else
            low_count <= low_count + 32'h1;
    end

    // Output flop; held value shown one cycle late, raw merged
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            req_o <= 1'b0;
        else
            req_o <= req_i || (enable_i && held && !(!ack_n_i && !req_i));
    end

    AST_RELEASE_ON_ACK: assert property (@(posedge clock_i) disable iff (!rstn_i)
        held && !req_i && !ack_n_i |=> !held)
        else $error("latch did not release on acknowledge");
    AST_HOLD_WHEN_SET: assert property (@(posedge clock_i) disable iff (!rstn_i)
        enable_i && req_i ##1 enable_i && ack_n_i |-> req_o)
        else $error("latched request not held");
    COV_RELEASE: cover property (@(posedge clock_i) held ##1 !held);

endmodule // drq_latch

// File: src/irq_router.sv
// Purpose: Gathers seven interrupt sources, masks, reports and routes them
// Assumes: APB slave, one clock, all pins synchronous to clock_i
// Notes:   Pin tristate shown by an enable; the bench resolves the wire
//
// Design decision made here: the APB register port.
`timescale 1ns/1ps

// How it works
// - Seven sources: two audio, volume, MIDI, three pins
// - Audio one cleared by resets or ack read
// - Extended control register enables audio one use
// - Channel two gated bit 6, bit 7 request
// - Channel two request sets when count exhausted
// - Volume event sets request, gated by bit 1
// - Volume request read bit 3, cleared writing 66h
// - MIDI request follows receive-data-available flag
// - MIDI request gated by bit 6
// - One MIDI routing register, at index 28h
// - Each internal source has its own routing register
// - Pins taken directly; GP off when DMA
// - Each source maps to one of five pins
// - Pin channel numbers loaded from configuration header
// - Pin drives when a mapped source active
// - Modem inactive when enable high or device off
// - Status bits 0-6 report the seven sources
// - Status bit 5 is modem and not enable
// - Latch enabled by bit 7, holds requests
// - Latch releases on ack, reset, or timeout
// - Mask bit per source, resets to ones
// - Status ignores the mask register
module irq_router
    import irq_route_pkg::*;
#(
    parameter int DRQ_HOLD = DRQ_HOLD_CYCLES,
    parameter int CH2_COUNT_W = 8
)(
    input  wire logic                clock_i,        // System clock
    input  wire logic                rstn_i,         // Sync reset, active low
    input  wire logic                psel_i,         // APB select
    input  wire logic                penable_i,      // APB access phase
    input  wire logic                pwrite_i,       // APB direction
    input  wire logic [11:0]         paddr_i,        // APB byte address
    input  wire logic [31:0]         pwdata_i,       // APB write data
    output logic      [31:0]         prdata_o,       // APB read data
    output logic                     pready_o,       // APB ready
    output logic                     pslverr_o,      // APB error, unmapped
    input  wire logic                a1_event_i,     // Audio one DMA/PIO event
    input  wire logic                ch2_byte_i,     // Channel two byte moved
    input  wire logic                vol_event_i,    // Any volume control event
    input  wire logic                midi_avail_i,   // MIDI receive data available
    input  wire logic                optical_drive_irq_in_i,  // Optical drive pin
    input  wire logic                modem_irq_in_i,          // Modem pin
    input  wire logic                modem_irq_enable_n_i,    // Modem enable, active low
    input  wire logic                general_purpose_irq_in_i, // GP pin
    input  wire logic                gp_is_drq_i,    // GP pin used as DMA request
    input  wire logic [7:0]          cfg_chan_i [3], // Header bytes for pin channels
    input  wire logic                cfg_load_i,     // Header load strobe
    input  wire drq_s                drq_i,          // Audio DMA requests and acks
    output logic      [2:0]          drq_o,          // Latched DMA requests
    output logic      [NUM_PINS-1:0] irq_o,          // Interrupt pin levels
    output logic      [NUM_PINS-1:0] irq_oe_o,       // Interrupt pin enables
    output logic      [23:0]         pin_chan_o      // ISA channel per pin pair
);

    ////////////////////////////////////////////////////////////////////
    // State
    logic [6:0]             source_mask_register;
    logic [7:0]             pin_chan [3];
    logic                   latch_en;
    route_s                 route [NUM_SRC];
    logic [4:0]             ldn_act;
    logic                   a1_req, a1_use;
    logic                   ch2_req, ch2_gate;
    logic [CH2_COUNT_W-1:0] ch2_reload, ch2_count;
    logic                   vol_req, vol_gate, midi_gate;
    logic [6:0]             src_raw, src_status;
    logic [6:0]             src_active;

    // APB decode; access phase only
    logic [7:0]  idx;
    logic        acc, wr, rd, mapped;
    logic        sw_reset;
    assign idx    = paddr_i[9:2];
    assign acc    = psel_i && penable_i;
    assign wr     = acc && pwrite_i && mapped;    // Refused accesses change nothing
    assign rd     = acc && !pwrite_i && mapped;
    assign sw_reset = wr && idx == IDX_SW_RESET;

    ////////////////////////////////////////////////////////////////////
    // Audio one: set by event when enabled, cleared by ack read
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i || sw_reset)
            a1_req <= 1'b0;
        else if (a1_event_i && a1_use)
            a1_req <= 1'b1;
        else if (rd && idx == IDX_A1_ACK)
            a1_req <= 1'b0;
    end

    // Channel two count; reloads on exhaustion, set beats clear
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            ch2_count <= CH2_COUNT_W'(CH2_COUNT_RESET);
            ch2_req   <= 1'b0;
        end
        else
        begin
            if (ch2_byte_i)
                ch2_count <= (ch2_count <= CH2_COUNT_W'(1)) ? ch2_reload : ch2_count - 1'b1;
            if (ch2_byte_i && ch2_count <= CH2_COUNT_W'(1))
                ch2_req <= 1'b1;
            else if (wr && idx == IDX_CH2_CTRL && !pwdata_i[BIT_CH2_REQ])
                ch2_req <= 1'b0;
        end
    end

    // Volume request; any write to the clear register drops it, event beats clear
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            vol_req <= 1'b0;
        else if (vol_event_i)
            vol_req <= 1'b1;
        else if (wr && idx == IDX_VOL_CLEAR)
            vol_req <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers written by software
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            source_mask_register <= MASK_RESET;
            latch_en   <= 1'b0;
            ldn_act    <= 5'h0;
            ch2_gate   <= 1'b0;
            vol_gate   <= 1'b0;
            midi_gate  <= 1'b0;
            a1_use     <= 1'b0;
            ch2_reload <= CH2_COUNT_W'(CH2_COUNT_RESET);
            for (int s = 0; s < NUM_SRC; s++)
                route[s] <= '0;
        end
        else if (wr)
        begin
            case (idx)
                IDX_SRC_MASK:    source_mask_register <= pwdata_i[6:0];
                IDX_DRQ_LATCH:   latch_en   <= pwdata_i[BIT_LATCH_EN];
                IDX_LDN_ACT:     ldn_act    <= pwdata_i[4:0];
                IDX_CH2_CTRL:    ch2_gate   <= pwdata_i[BIT_CH2_GATE];
                IDX_VOL_CTRL:
                begin
                    vol_gate  <= pwdata_i[BIT_VOL_GATE];
                    midi_gate <= pwdata_i[BIT_MIDI_GATE];
                end
                IDX_A1_EXT_CTRL: a1_use     <= pwdata_i[0];
                IDX_CH2_COUNT:   ch2_reload <= pwdata_i[CH2_COUNT_W-1:0];
                IDX_A1_ROUTE:    route[SRC_A1]   <= pwdata_i[3:0];
                IDX_A2_ROUTE:    route[SRC_A2]   <= pwdata_i[3:0];
                IDX_HWVOL_ROUTE: route[SRC_VOL]  <= pwdata_i[3:0];
                IDX_MIDI_ROUTE:  route[SRC_MIDI] <= pwdata_i[3:0];
                default:         ;
            endcase
            // Pin sources route through the same chosen slots above C6h
            if (idx >= 8'hc8 && idx <= 8'hca)
                route[SRC_CD + 32'(idx - 8'hc8)] <= pwdata_i[3:0];
        end
    end

    // Pin channel numbers; header load wins over software write
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            for (int p = 0; p < 3; p++)
                pin_chan[p] <= PIN_CHAN_RESET;
        else if (cfg_load_i)
            for (int p = 0; p < 3; p++)
                pin_chan[p] <= cfg_chan_i[p];
        else if (wr && idx >= IDX_PIN_CHAN0 && idx <= IDX_PIN_CHAN2)
            pin_chan[2'(idx - IDX_PIN_CHAN0)] <= pwdata_i[7:0];
    end

    ////////////////////////////////////////////////////////////////////
    // Source levels; status taken before the mask
    always_comb
    begin
        src_raw[SRC_A1]    = a1_req;
        src_raw[SRC_A2]    = ch2_req && ch2_gate;
        src_raw[SRC_VOL]   = vol_req && vol_gate;
        src_raw[SRC_MIDI]  = midi_avail_i && midi_gate;
        src_raw[SRC_CD]    = optical_drive_irq_in_i;
        src_raw[SRC_MODEM] = modem_irq_in_i && !modem_irq_enable_n_i;
        src_raw[SRC_GP]    = general_purpose_irq_in_i && !gp_is_drq_i;
        src_status         = src_raw;
    end

    // Which sources keep their pin driven
    always_comb
    begin
        src_active[SRC_A1]    = ldn_act[LDN_AUDIO];
        src_active[SRC_A2]    = ldn_act[LDN_AUDIO];
        src_active[SRC_VOL]   = ldn_act[LDN_AUDIO];
        src_active[SRC_MIDI]  = ldn_act[LDN_MIDI];
        src_active[SRC_CD]    = ldn_act[LDN_CD];
        src_active[SRC_MODEM] = ldn_act[LDN_MODEM] && !modem_irq_enable_n_i;
        src_active[SRC_GP]    = ldn_act[LDN_GP] && !gp_is_drq_i;
    end

    // Per pin: OR of masked requests, enable when any source active
    genvar gp;
    generate
        for (gp = 0; gp < NUM_PINS; gp++)
        begin : g_pin
            logic lvl, en;
            always_comb
            begin
                lvl = 1'b0;
                en  = 1'b0;
                for (int s = 0; s < NUM_SRC; s++)
                    if (route[s].valid && route[s].pin == 3'(gp))
                    begin
                        lvl = lvl | (src_raw[s] & source_mask_register[s]);
                        en  = en | src_active[s];
                    end
            end
            always_ff @(posedge clock_i)
            begin
                if (!rstn_i)
                begin
                    irq_o[gp]    <= 1'b0;
                    irq_oe_o[gp] <= 1'b0;
                end
                else
                begin
                    irq_o[gp]    <= lvl;
                    irq_oe_o[gp] <= en;
                end
            end
        end
    endgenerate

    // Channel numbers out through a flop
    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
            pin_chan_o <= 24'h0;
        else
            pin_chan_o <= {pin_chan[2], pin_chan[1], pin_chan[0]};
    end

    ////////////////////////////////////////////////////////////////////
    // DMA request latches, one per audio request
    genvar gd;
    generate
        for (gd = 0; gd < 3; gd++)
        begin : g_drq
            drq_latch #(
                .HOLD_CYCLES (DRQ_HOLD)
            ) u_latch (
                .clock_i  (clock_i),
                .rstn_i   (rstn_i),
                .enable_i (latch_en),
                .req_i    (drq_i.req[gd]),
                .ack_n_i  (drq_i.ack_n[gd]),
                .req_o    (drq_o[gd])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // APB read and answer; one wait-free access, ready in access phase
    always_comb
    begin
        mapped = 1'b1;
        case (idx)
            IDX_SRC_STATUS, IDX_SRC_MASK, IDX_PIN_CHAN0, IDX_PIN_CHAN1, IDX_PIN_CHAN2,
            IDX_DRQ_LATCH, IDX_HWVOL_ROUTE, IDX_MIDI_ROUTE, IDX_VOL_CTRL, IDX_VOL_CLEAR,
            IDX_CH2_CTRL, IDX_A1_EXT_CTRL, IDX_A1_ROUTE, IDX_A2_ROUTE, IDX_LDN_ACT,
            IDX_A1_POLL, IDX_A1_ACK, IDX_CH2_COUNT, IDX_SW_RESET,
            8'hc8, 8'hc9, 8'hca: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
        if (paddr_i[11:10] != 2'b00)
            mapped = 1'b0;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rstn_i)
        begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            pready_o  <= psel_i && !penable_i;
            pslverr_o <= psel_i && !penable_i && !mapped;
            prdata_o  <= 32'h0;
            if (psel_i && !penable_i && !pwrite_i)
                case (idx)
                    IDX_SRC_STATUS:  prdata_o <= {25'h0, src_status};
                    IDX_SRC_MASK:    prdata_o <= {25'h0, source_mask_register};
                    IDX_PIN_CHAN0:   prdata_o <= {24'h0, pin_chan[0]};
                    IDX_PIN_CHAN1:   prdata_o <= {24'h0, pin_chan[1]};
                    IDX_PIN_CHAN2:   prdata_o <= {24'h0, pin_chan[2]};
                    IDX_DRQ_LATCH:   prdata_o <= {24'h0, latch_en, 7'h0};
                    IDX_VOL_CTRL:    prdata_o <= {25'h0, midi_gate, 2'b00, vol_req, 1'b0, vol_gate, 1'b0};
                    IDX_CH2_CTRL:    prdata_o <= {24'h0, ch2_req, ch2_gate, 6'h0};
                    IDX_A1_EXT_CTRL: prdata_o <= {31'h0, a1_use};
                    IDX_A1_POLL:     prdata_o <= {24'h0, a1_req, 7'h0};
                    IDX_LDN_ACT:     prdata_o <= {27'h0, ldn_act};
                    IDX_CH2_COUNT:   prdata_o <= 32'(ch2_reload);
                    IDX_MIDI_ROUTE:  prdata_o <= {28'h0, route[SRC_MIDI]};
                    default:         prdata_o <= 32'h0;
                endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    AST_MASK_RESET: assert property (@(posedge clock_i)
        !rstn_i |=> source_mask_register == MASK_RESET)
        else $error("mask not all ones after reset");
    AST_VOL_CLEAR: assert property (@(posedge clock_i) disable iff (!rstn_i)
        wr && idx == IDX_VOL_CLEAR && !vol_event_i |=> !vol_req)
        else $error("volume request not cleared");
    AST_A1_ACK: assert property (@(posedge clock_i) disable iff (!rstn_i)
        rd && idx == IDX_A1_ACK && !(a1_event_i && a1_use) |=> !a1_req)
        else $error("audio one not cleared by ack read");
    AST_MODEM_STATUS: assert property (@(posedge clock_i) disable iff (!rstn_i)
        modem_irq_enable_n_i |-> !src_status[SRC_MODEM])
        else $error("modem status with enable high");
    AST_STATUS_NO_MASK: assert property (@(posedge clock_i) disable iff (!rstn_i)
        optical_drive_irq_in_i |-> src_status[SRC_CD])
        else $error("status affected by mask");
    AST_GP_DRQ: assert property (@(posedge clock_i) disable iff (!rstn_i)
        gp_is_drq_i |-> !src_status[SRC_GP])
        else $error("gp pin reported while dma");
    AST_PIN_OR: assert property (@(posedge clock_i) disable iff (!rstn_i)
        route[SRC_CD].valid && source_mask_register[SRC_CD] && optical_drive_irq_in_i
        |=> irq_o[$past(route[SRC_CD].pin)])
        else $error("routed source not on pin");
    AST_CH2_SET: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ch2_byte_i && ch2_count <= CH2_COUNT_W'(1) |=> ch2_req)
        else $error("channel two request not set");
    AST_PIN_HIZ: assert property (@(posedge clock_i) disable iff (!rstn_i)
        ldn_act == 5'h0 |=> irq_oe_o == '0)
        else $error("pin driven with no active device");
    COV_CH2: cover property (@(posedge clock_i) ch2_req);
    COV_PIN: cover property (@(posedge clock_i) irq_oe_o[0] && irq_o[0]);
    COV_VOL: cover property (@(posedge clock_i) vol_req ##1 !vol_req);

endmodule // irq_router

// File: verif/isa_host_model.sv
// Purpose: Host side of the interrupt pins and DMA acknowledge lines
// Assumes: Pins are tristate with no pull, acks are one cycle pulses
// Notes:   Released pins toggle so a stale level can never pass a check
`timescale 1ns/1ps
module isa_host_model
    import irq_route_pkg::*;
(
    input  wire logic [NUM_PINS-1:0] irq_i,   // Device pin levels
    input  wire logic [NUM_PINS-1:0] oe_i,    // Device pin enables
    input  wire logic                clock_i, // System clock
    input  wire logic [2:0]          go_i,    // Ask for an acknowledge
    output logic      [NUM_PINS-1:0] line_o,  // Resolved pin wires
    output logic      [2:0]          ack_n_o  // DMA acknowledge, active low
);
    logic [NUM_PINS-1:0] last = '0;
    // Undriven wire shows the inverse of its last level
    assign line_o = (oe_i & irq_i) | (~oe_i & ~last);
    // One low acknowledge cycle per request
    always_ff @(posedge clock_i)
    begin
        last <= line_o;
        ack_n_o <= ~go_i;
    end
endmodule // isa_host_model

// File: verif/audio_irq_routing_and_drq_latch_tb_top.sv
// Purpose: Self-checking bench for the interrupt router and DMA latch
// Assumes: Zero wait state APB, pins settle one cycle after their cause
// Notes:   Latch hold shortened to 20 cycles to keep the run short
`timescale 1ns/1ps
module audio_irq_routing_and_drq_latch_tb_top;
    import irq_route_pkg::*;
    logic clock_i = 1'b0, rstn_i = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0, err, pready, pslverr;
    logic a1 = 1'b0, vol = 1'b0, midi = 1'b0, cd = 1'b0, mdm = 1'b0, mdm_en_n = 1'b1, gp = 1'b0;
    logic ch2b = 1'b0, gpdrq = 1'b0, cload = 1'b0;
    logic [23:0] pch;
    logic [11:0] addr = 12'h000;
    logic [31:0] wd = 32'h0, rd, prdata;
    logic [2:0]  req = 3'h0, go = 3'h0, ack_n, drq;
    logic [4:0]  irq, oe, line;
    logic [7:0]  chan [3] = '{default: 8'h00};
    drq_s        drq_in;
    int          n_fail = 0, compares = 0;
    assign drq_in = {req, ack_n};
    always #12.5 clock_i = ~clock_i;
    irq_router #(.DRQ_HOLD(20)) u_irq_router (.clock_i(clock_i), .rstn_i(rstn_i), .psel_i(psel),
        .penable_i(pen), .pwrite_i(pwr), .paddr_i(addr), .pwdata_i(wd), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .a1_event_i(a1), .ch2_byte_i(ch2b), .vol_event_i(vol),
        .midi_avail_i(midi), .optical_drive_irq_in_i(cd), .modem_irq_in_i(mdm),
        .modem_irq_enable_n_i(mdm_en_n), .general_purpose_irq_in_i(gp), .gp_is_drq_i(gpdrq),
        .cfg_chan_i(chan), .cfg_load_i(cload), .drq_i(drq_in), .drq_o(drq), .irq_o(irq),
        .irq_oe_o(oe), .pin_chan_o(pch));
    isa_host_model u_isa_host_model (.irq_i(irq), .oe_i(oe), .clock_i(clock_i), .go_i(go),
        .line_o(line), .ack_n_o(ack_n));
    ////////////////////////////////////////////////////////////////////////////////
    // Compare and count, mismatch reported at once
    task chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One APB transfer, held until pready is seen at an edge
    task apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        int n;
        @(posedge clock_i);
        psel <= 1'b1;
        pwr <= w;
        addr <= {2'b00, idx, 2'b00};
        wd <= d;
        @(posedge clock_i);
        pen <= 1'b1;
        n = 0;
        do @(posedge clock_i); while (pready !== 1'b1 && ++n < 20);
        if (pready !== 1'b1)
            n_fail++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task give_verdict;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Mask reset value, pin sources in status, status blind to mask
    task t_regs;
        apb(1'b0, IDX_SRC_MASK, 32'h0);
        chk(rd, 32'h7f);
        cd <= 1'b1;
        mdm <= 1'b1;
        mdm_en_n <= 1'b0;
        gp <= 1'b1;
        apb(1'b0, IDX_SRC_STATUS, 32'h0);
        chk(rd, 32'h70);
        mdm_en_n <= 1'b1;
        apb(1'b1, IDX_SRC_MASK, 32'h0);
        apb(1'b0, IDX_SRC_STATUS, 32'h0);
        chk(rd, 32'h50);
        apb(1'b0, 8'hff, 32'h0);
        chk({31'h0, err}, 32'h1); // Unmapped index flagged
        chk(rd, 32'h0); // Unmapped index reads zero
        apb(1'b1, IDX_SRC_MASK, 32'h7f);
        {cd, mdm, gp} <= 3'b000;
        // Header load reaches the channel registers and the output
        chan <= '{8'h05, 8'h07, 8'h0a};
        cload <= 1'b1;
        @(posedge clock_i);
        cload <= 1'b0;
        repeat (2) @(posedge clock_i);
        chk(pch, 24'h0a0705);
        apb(1'b0, IDX_PIN_CHAN1, 32'h0);
        chk(rd, 32'h07);
    endtask
    // Internal sources set, gated, reported and cleared
    task t_src;
        apb(1'b1, IDX_A1_EXT_CTRL, 32'h1);
        apb(1'b1, IDX_VOL_CTRL, 32'h42);
        {a1, vol, midi} <= 3'b111;
        @(posedge clock_i);
        {a1, vol} <= 2'b00;
        apb(1'b0, IDX_SRC_STATUS, 32'h0);
        chk(rd, 32'h0d);
        apb(1'b0, IDX_A1_POLL, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, IDX_VOL_CTRL, 32'h0);
        chk(rd[3], 1'b1);
        apb(1'b1, IDX_VOL_CLEAR, 32'h5a);
        apb(1'b0, IDX_A1_ACK, 32'h0);
        midi <= 1'b0;
        apb(1'b0, IDX_SRC_STATUS, 32'h0);
        chk(rd, 32'h0);
    endtask
    // Channel two request after the reload count of bytes, then cleared
    task t_ch2;
        apb(1'b1, IDX_CH2_CTRL, 32'h40);
        ch2b <= 1'b1;
        repeat (63) @(posedge clock_i);
        ch2b <= 1'b0;
        apb(1'b0, IDX_CH2_CTRL, 32'h0);
        chk(rd, 32'h40);
        ch2b <= 1'b1;
        @(posedge clock_i);
        ch2b <= 1'b0;
        apb(1'b0, IDX_SRC_STATUS, 32'h0);
        chk(rd, 32'h02);
        apb(1'b1, IDX_CH2_CTRL, 32'h0);
        apb(1'b0, IDX_CH2_CTRL, 32'h0);
        chk(rd, 32'h0);
    endtask
    // Two sources shared on pin 2, OR and mask
    task t_route;
        apb(1'b1, IDX_LDN_ACT, 32'h12);
        apb(1'b1, 8'hc8, 32'h0a);
        apb(1'b1, 8'hca, 32'h0a);
        cd <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({oe, line[2]}, {5'h04, 1'b1});
        {cd, gp} <= 2'b01;
        repeat (3) @(posedge clock_i);
        chk(line[2], 1'b1);
        gpdrq <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk({oe, line[2]}, {5'h04, 1'b0});
        gpdrq <= 1'b0;
        {cd, gp} <= 2'b10;
        apb(1'b1, IDX_SRC_MASK, 32'h6f);
        repeat (3) @(posedge clock_i);
        chk({oe, line[2]}, {5'h04, 1'b0});
        cd <= 1'b0;
    endtask
    // Latch holds, releases on acknowledge, then on the hold timer
    task t_drq;
        apb(1'b1, IDX_DRQ_LATCH, 32'h80);
        req <= 3'h1;
        @(posedge clock_i);
        req <= 3'h0;
        repeat (5) @(posedge clock_i);
        chk(drq, 3'h1);
        go <= 3'h1;
        @(posedge clock_i);
        go <= 3'h0;
        repeat (4) @(posedge clock_i);
        chk(drq, 3'h0);
        req <= 3'h1;
        @(posedge clock_i);
        req <= 3'h0;
        repeat (10) @(posedge clock_i);
        chk(drq, 3'h1);
        repeat (40) @(posedge clock_i);
        chk(drq, 3'h0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence after a five cycle reset
    initial
    begin
        repeat (5) @(posedge clock_i);
        rstn_i <= 1'b1;
        t_regs;
        t_src;
        t_ch2;
        t_route;
        t_drq;
        give_verdict;
    end
    // Watchdog, well past the few hundred cycles the tests need
    initial
    begin
        repeat (3000) @(posedge clock_i);
        n_fail++;
        give_verdict;
    end
endmodule // audio_irq_routing_and_drq_latch_tb_top
